/* isr_pkg.sv */
package isr_pkg;
  // Widths of the datapath
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PTR_W  = 16;
  localparam int unsigned PC_W   = 15;
  localparam int unsigned OFS_W  = 6;

  // Instruction classes handed over by the fetch path
  typedef enum logic [2:0] {
    OP_IDLE    = 3'h0,
    OP_STORE   = 3'h1,
    OP_OPTION  = 3'h2,
    OP_RESTART = 3'h3,
    OP_RETINT  = 3'h4,
    OP_RETLIT  = 3'h5
  } isr_op_t;

  // Pointer adjustment codes
  localparam logic [1:0] MODE_PRE_INC  = 2'h0;
  localparam logic [1:0] MODE_PRE_DEC  = 2'h1;
  localparam logic [1:0] MODE_POST_INC = 2'h2;
  localparam logic [1:0] MODE_POST_DEC = 2'h3;

  // Sequencer states, Gray coded
  typedef enum logic [1:0] {
    ST_RUN    = 2'h0,
    ST_SECOND = 2'h1
  } isr_state_t;

  // Reset values and constants
  localparam logic [PTR_W-1:0]  PTR_RST    = 16'h0000;
  localparam logic [PTR_W-1:0]  PTR_ONE    = 16'h0001;
  localparam logic [PTR_W-1:0]  PTR_TOP    = 16'hFFFF;
  localparam logic [DATA_W-1:0] OPTION_RST = 8'hFF;
  localparam logic [DATA_W-1:0] DATA_ZERO  = 8'h00;
  localparam logic [PC_W-1:0]   PC_ZERO    = 15'h0000;
  localparam int unsigned       INT_EN_BIT  = 7;
  localparam logic [DATA_W-1:0] INT_EN_MASK = 8'h80;
endpackage : isr_pkg

/* isr_ptr_calc.sv */
`timescale 1ns/100ps
// Effective address and updated pointer for one indirect store
module isr_ptr_calc
  import isr_pkg::*;
(
  // Current pointer and addressing form
  input  wire logic [PTR_W-1:0] ptr,
  input  wire logic [1:0]       mode,
  input  wire logic             rel_form,
  input  wire logic [OFS_W-1:0] offset,
  // Results
  output logic      [PTR_W-1:0] eff_addr,
  output logic      [PTR_W-1:0] nxt_ptr
);
  logic [PTR_W-1:0] ptr_inc;
  logic [PTR_W-1:0] ptr_dec;
  logic [PTR_W-1:0] ofs_ext;

  // Modulo 2^16 arithmetic gives the wrap at both ends for free
  assign ptr_inc = PTR_W'(ptr + PTR_ONE);                             // RULE4
  assign ptr_dec = PTR_W'(ptr - PTR_ONE);                             // RULE4
  assign ofs_ext = {{(PTR_W-OFS_W){offset[OFS_W-1]}}, offset};

  // Pre forms address the adjusted value, post forms the old one
  always_comb
  begin
    eff_addr = ptr;
    nxt_ptr  = ptr;
    if (rel_form)
    begin
      eff_addr = PTR_W'(ptr + ofs_ext);                               // RULE3
      nxt_ptr  = ptr;                                                 // RULE3
    end
    else
    begin
      unique case (mode)                                              // RULE2
        MODE_PRE_INC:
        begin
          eff_addr = ptr_inc;
          nxt_ptr  = ptr_inc;
        end
        MODE_PRE_DEC:
        begin
          eff_addr = ptr_dec;
          nxt_ptr  = ptr_dec;
        end
        MODE_POST_INC:
        begin
          eff_addr = ptr;
          nxt_ptr  = ptr_inc;
        end
        MODE_POST_DEC:
        begin
          eff_addr = ptr;
          nxt_ptr  = ptr_dec;
        end
      endcase
    end
  end
endmodule : isr_ptr_calc

/* isr_exec.sv */
`timescale 1ns/100ps
// Summary of operation
// RULE1 - Store accumulator at address held by selected pointer
// RULE2 - Mode code picks pre/post increment/decrement
// RULE3 - Relative form: pointer plus signed offset, pointer kept
// RULE4 - Sixteen-bit pointer wraps at both ends
// RULE5 - Indirect store never alters status flags
// RULE6 - Idle: one cycle, only program counter advances
// RULE7 - Option load copies accumulator, flags untouched
// RULE8 - Restart instruction requests full device reset
// RULE9 - Restart instruction clears restart indicator flag
// RULE10 - Return-from-interrupt pops stack, loads counter, two cycles
// RULE11 - Return-from-interrupt sets global interrupt enable bit
// RULE12 - Return-with-literal loads accumulator and counter, two cycles
module isr_exec
  import isr_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              ce,
  // Decoded instruction
  input  wire logic              instr_valid,
  input  wire isr_op_t           instr_op,
  input  wire logic              ptr_sel,
  input  wire logic [1:0]        pointer_mode_code,
  input  wire logic              rel_form,
  input  wire logic [OFS_W-1:0]  rel_offset,
  input  wire logic [DATA_W-1:0] literal,
  // Core state
  input  wire logic [DATA_W-1:0] acc_in,
  input  wire logic [PC_W-1:0]   stack_top,
  input  wire logic              restart_flag_set,
  // Sequencing
  output logic                   instr_ready,
  output logic                   pc_advance,
  // Data memory write
  output logic                   mem_wr_en,
  output logic [PTR_W-1:0]       mem_addr,
  output logic [DATA_W-1:0]      mem_wr_data,
  // Pointers and configuration
  output logic [PTR_W-1:0]       file_select_pointer0,
  output logic [PTR_W-1:0]       file_select_pointer1,
  output logic [DATA_W-1:0]      option_reg,
  output logic                   software_restart_flag,
  output logic                   restart_req,
  // Accumulator, flags, stack, interrupts
  output logic                   acc_wr_en,
  output logic [DATA_W-1:0]      acc_wr_data,
  output logic                   status_wr_en,
  output logic                   stack_pop,
  output logic                   pc_load,
  output logic [PC_W-1:0]        pc_load_val,
  output logic [DATA_W-1:0]      int_ctl_set_mask
);
  typedef struct packed {
    isr_state_t                  state;
    logic [1:0][PTR_W-1:0]       ptr;
    logic [DATA_W-1:0]           option;
    logic                        restart_flag;
    logic                        ready;
    logic                        pc_adv;
    logic                        mem_we;
    logic [PTR_W-1:0]            mem_addr;
    logic [DATA_W-1:0]           mem_wd;
    logic                        acc_we;
    logic [DATA_W-1:0]           acc_wd;
    logic                        status_we;
    logic                        pop;
    logic                        pc_ld;
    logic [PC_W-1:0]             pc_val;
    logic [DATA_W-1:0]           int_mask;
    logic                        restart;
  } isr_regs_t;

  isr_regs_t        st_ff;
  isr_regs_t        nxt_st;
  logic [PTR_W-1:0] cur_ptr;
  logic [PTR_W-1:0] eff_addr;
  logic [PTR_W-1:0] upd_ptr;
  logic             take;

  assign cur_ptr = st_ff.ptr[ptr_sel];                                // RULE1
  assign take    = ce && instr_valid && st_ff.ready;

  isr_ptr_calc u_calc (
    .ptr      (cur_ptr),
    .mode     (pointer_mode_code),
    .rel_form (rel_form),
    .offset   (rel_offset),
    .eff_addr (eff_addr),
    .nxt_ptr  (upd_ptr)
  );

  // Next state: pulse outputs default low, held state keeps its value
  always_comb
  begin
    nxt_st           = st_ff;
    nxt_st.pc_adv    = 1'b0;
    nxt_st.mem_we    = 1'b0;
    nxt_st.acc_we    = 1'b0;
    nxt_st.status_we = 1'b0;                                          // RULE5
    nxt_st.pop       = 1'b0;
    nxt_st.pc_ld     = 1'b0;
    nxt_st.int_mask  = DATA_ZERO;
    nxt_st.restart   = 1'b0;
    // Set from outside wins only when no restart executes this cycle
    if (restart_flag_set)
    begin
      nxt_st.restart_flag = 1'b1;
    end
    unique case (st_ff.state)
      ST_RUN:
      begin
        if (take)
        begin
          unique case (instr_op)
            OP_IDLE:
            begin
              nxt_st.pc_adv = 1'b1;                                   // RULE6
            end
            OP_STORE:
            begin
              nxt_st.pc_adv       = 1'b1;
              nxt_st.mem_we       = 1'b1;                             // RULE1
              nxt_st.mem_addr     = eff_addr;                         // RULE2
              nxt_st.mem_wd       = acc_in;                           // RULE1
              nxt_st.ptr[ptr_sel] = upd_ptr;                          // RULE3
            end
            OP_OPTION:
            begin
              nxt_st.pc_adv = 1'b1;
              nxt_st.option = acc_in;                                 // RULE7
            end
            OP_RESTART:
            begin
              // Counter does not advance: the device is going down
              nxt_st.restart      = 1'b1;                             // RULE8
              nxt_st.restart_flag = 1'b0;                             // RULE9
            end
            OP_RETINT:
            begin
              nxt_st.pop      = 1'b1;                                 // RULE10
              nxt_st.pc_ld    = 1'b1;
              nxt_st.pc_val   = stack_top;
              nxt_st.int_mask = INT_EN_MASK;                          // RULE11
              nxt_st.ready    = 1'b0;
              nxt_st.state    = ST_SECOND;
            end
            OP_RETLIT:
            begin
              nxt_st.pop    = 1'b1;                                   // RULE12
              nxt_st.pc_ld  = 1'b1;
              nxt_st.pc_val = stack_top;
              nxt_st.acc_we = 1'b1;
              nxt_st.acc_wd = literal;                                // RULE12
              nxt_st.ready  = 1'b0;
              nxt_st.state  = ST_SECOND;
            end
            default:
            begin
              // Unknown class behaves as idle so the program never hangs
              nxt_st.pc_adv = 1'b1;
            end
          endcase
        end
      end
      ST_SECOND:
      begin
        // Dead cycle of two-cycle returns, the fetched word is flushed
        nxt_st.ready = 1'b1;                                          // RULE10
        nxt_st.state = ST_RUN;
      end
      default:
      begin
        nxt_st.ready = 1'b1;
        nxt_st.state = ST_RUN;
      end
    endcase
  end

  // Single state register, frozen while the clock enable is low
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_ff              <= '0;
      st_ff.state        <= ST_RUN;
      st_ff.ptr[0]       <= PTR_RST;
      st_ff.ptr[1]       <= PTR_RST;
      st_ff.option       <= OPTION_RST;
      st_ff.restart_flag <= 1'b1;
      st_ff.ready        <= 1'b1;
      st_ff.pc_val       <= PC_ZERO;
    end
    else if (ce)
    begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign instr_ready           = st_ff.ready;
  assign pc_advance            = st_ff.pc_adv;
  assign mem_wr_en             = st_ff.mem_we;
  assign mem_addr              = st_ff.mem_addr;
  assign mem_wr_data           = st_ff.mem_wd;
  assign file_select_pointer0  = st_ff.ptr[0];
  assign file_select_pointer1  = st_ff.ptr[1];
  assign option_reg            = st_ff.option;
  assign software_restart_flag = st_ff.restart_flag;
  assign restart_req           = st_ff.restart;
  assign acc_wr_en             = st_ff.acc_we;
  assign acc_wr_data           = st_ff.acc_wd;
  assign status_wr_en          = st_ff.status_we;
  assign stack_pop             = st_ff.pop;
  assign pc_load               = st_ff.pc_ld;
  assign pc_load_val           = st_ff.pc_val;
  assign int_ctl_set_mask      = st_ff.int_mask;

  // Checks on the executed instructions
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_store_data: assert property (take && instr_op == OP_STORE |=> // RULE1
    mem_wr_en && mem_wr_data == $past(acc_in)) else $error("store data wrong");
  a_pre_inc: assert property (take && instr_op == OP_STORE && !rel_form // RULE2
    && !ptr_sel && pointer_mode_code == MODE_PRE_INC |=>
    mem_addr == PTR_W'($past(file_select_pointer0) + PTR_ONE)
    && file_select_pointer0 == mem_addr) else $error("pre increment wrong");
  a_post_dec: assert property (take && instr_op == OP_STORE && !rel_form // RULE2
    && ptr_sel && pointer_mode_code == MODE_POST_DEC |=>
    mem_addr == $past(file_select_pointer1)
    && file_select_pointer1 == PTR_W'(mem_addr - PTR_ONE)) else $error("post decrement wrong");
  a_rel_keep: assert property (take && instr_op == OP_STORE && rel_form // RULE3
    |=> $stable(file_select_pointer0) && $stable(file_select_pointer1))
    else $error("relative form moved pointer");
  a_ptr_wrap: assert property (take && instr_op == OP_STORE && !rel_form // RULE4
    && !ptr_sel && pointer_mode_code == MODE_POST_INC
    && file_select_pointer0 == PTR_TOP |=> file_select_pointer0 == PTR_RST)
    else $error("pointer did not wrap");
  a_no_flags: assert property (take |=> !status_wr_en) // RULE5
    else $error("status flags written");
  a_idle_only: assert property (take && instr_op == OP_IDLE |=> pc_advance // RULE6
    && !mem_wr_en && !acc_wr_en && !pc_load && $stable(option_reg))
    else $error("idle changed state");
  a_option_copy: assert property (take && instr_op == OP_OPTION // RULE7
    |=> option_reg == $past(acc_in)) else $error("option not loaded");
  a_restart_req: assert property (take && instr_op == OP_RESTART // RULE8
    |=> restart_req && !pc_advance) else $error("restart not requested");
  a_restart_flag: assert property (restart_req |-> !software_restart_flag) // RULE9
    else $error("restart flag not cleared");
  a_retint_pop: assert property (take && instr_op == OP_RETINT |=> stack_pop // RULE10
    && pc_load && pc_load_val == $past(stack_top) && !instr_ready)
    else $error("return from interrupt wrong");
  a_int_enable_set: assert property (take && instr_op == OP_RETINT // RULE11
    |=> int_ctl_set_mask[INT_EN_BIT]) else $error("interrupt enable not set");
  a_retlit_acc: assert property (take && instr_op == OP_RETLIT |=> acc_wr_en // RULE12
    && acc_wr_data == $past(literal) && pc_load && !instr_ready)
    else $error("return with literal wrong");

  c_store_rel: cover property (take && instr_op == OP_STORE && rel_form);
  c_wrap_dn: cover property (take && instr_op == OP_STORE && !rel_form
    && file_select_pointer0 == PTR_RST);
  c_ret_back: cover property (take && instr_op == OP_RETINT ##2 take);
  c_restart: cover property (take && instr_op == OP_RESTART);
endmodule : isr_exec

/* indirect_store_and_return_ops_bench.sv */
`timescale 1ns/100ps
module indirect_store_and_return_ops_bench;
  import isr_pkg::*;
  // Stimulus and observed ports
  logic              clk, sys_rst, ce, instr_valid, ptr_sel, rel_form, restart_flag_set;
  isr_op_t           instr_op;
  logic [1:0]        pointer_mode_code;
  logic [OFS_W-1:0]  rel_offset;
  logic [DATA_W-1:0] literal, acc_in, option_reg, acc_wr_data, mem_wr_data, int_ctl_set_mask;
  logic [PC_W-1:0]   stack_top, pc_load_val;
  logic              instr_ready, pc_advance, mem_wr_en, software_restart_flag, restart_req;
  logic              acc_wr_en, status_wr_en, stack_pop, pc_load;
  logic [PTR_W-1:0]  mem_addr, file_select_pointer0, file_select_pointer1;
  int                miscompares, check_count;
  // Reference state: pointers, option, flag and the held output values
  int                m_ptr[2];
  int                m_opt, m_flag, m_addr, m_data, m_acc, m_pcv, m_op;

  isr_exec dut_u (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .instr_valid(instr_valid), .instr_op(instr_op),
    .ptr_sel(ptr_sel), .pointer_mode_code(pointer_mode_code), .rel_form(rel_form),
    .rel_offset(rel_offset), .literal(literal), .acc_in(acc_in), .stack_top(stack_top),
    .restart_flag_set(restart_flag_set), .instr_ready(instr_ready), .pc_advance(pc_advance),
    .mem_wr_en(mem_wr_en), .mem_addr(mem_addr), .mem_wr_data(mem_wr_data),
    .file_select_pointer0(file_select_pointer0), .file_select_pointer1(file_select_pointer1),
    .option_reg(option_reg), .software_restart_flag(software_restart_flag),
    .restart_req(restart_req), .acc_wr_en(acc_wr_en), .acc_wr_data(acc_wr_data),
    .status_wr_en(status_wr_en), .stack_pop(stack_pop), .pc_load(pc_load),
    .pc_load_val(pc_load_val), .int_ctl_set_mask(int_ctl_set_mask)
  );

  // 250 MHz core clock
  always #2 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Compares every output against the reference after a taken instruction
  task automatic check_all();
    bit rt, rl;
    rt = (m_op == 4);
    rl = (m_op == 5);
    chk(mem_wr_en, m_op == 1);
    chk(mem_addr, m_addr);
    chk(mem_wr_data, m_data);
    chk(file_select_pointer0, m_ptr[0]);
    chk(file_select_pointer1, m_ptr[1]);
    chk(option_reg, m_opt);
    chk(software_restart_flag, m_flag);
    chk(restart_req, m_op == 3);
    chk(status_wr_en, 0);
    chk(pc_advance, m_op inside {0, 1, 2, 6, 7});
    chk(stack_pop, rt || rl);
    chk(pc_load, rt || rl);
    chk(pc_load_val, m_pcv);
    chk(int_ctl_set_mask, rt ? 8'h80 : 8'h00);
    chk(acc_wr_en, rl);
    chk(acc_wr_data, m_acc);
    chk(instr_ready, !(rt || rl));
  endtask : check_all

  // Offers one instruction, holds it until taken, then updates the reference
  task automatic do_op(input int op, input int sel, input int mode, input int rel,
                       input int ofs, input int set);
    int p;
    int a;
    instr_op          = isr_op_t'(op[2:0]);
    ptr_sel           = sel[0];
    pointer_mode_code = mode[1:0];
    rel_form          = rel[0];
    rel_offset        = ofs[5:0];
    literal           = 8'($urandom);
    acc_in            = 8'($urandom);
    stack_top         = 15'($urandom);
    restart_flag_set  = set[0];
    instr_valid       = 1'b1;
    // Offers while not ready must be ignored, so nothing may pulse meanwhile
    for (int w = 0; w < 4 && instr_ready !== 1'b1; w++)
    begin
      @(posedge clk);
      #1;
      chk(pc_advance | mem_wr_en | restart_req | stack_pop | pc_load | acc_wr_en, 0);
    end
    @(posedge clk);
    #1;
    m_op = op;
    p    = m_ptr[sel];
    case (op)
      1:
      begin
        if (rel)
          a = p + ofs;
        else
          case (mode)
            0: begin p++; a = p; end
            1: begin p--; a = p; end
            2: begin a = p; p++; end
            default: begin a = p; p--; end
          endcase
        m_ptr[sel] = p & 32'h0000_ffff;
        m_addr     = a & 32'h0000_ffff;
        m_data     = acc_in;
      end
      2: m_opt = acc_in;
      3: m_flag = 0;
      4: m_pcv = stack_top;
      5: begin m_pcv = stack_top; m_acc = literal; end
      default: ;
    endcase
    // The clear from the restart instruction wins over a set request
    if (set != 0 && op != 3)
      m_flag = 1;
    check_all();
  endtask : do_op

  task automatic do_reset();
    sys_rst     = 1'b1;
    instr_valid = 1'b0;
    repeat (2) @(posedge clk);
    #1 sys_rst  = 1'b0;
    m_ptr  = '{0, 0};
    m_opt  = 8'hff;
    m_flag = 1;
    m_op   = -1;
    m_addr = 0;
    m_data = 0;
    m_acc  = 0;
    m_pcv  = 0;
    check_all();
  endtask : do_reset

  task automatic close_out();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // Hang guard: the whole sequence needs well under 20 us
  initial
  begin
    #20_000;
    miscompares++;
    close_out();
  end

  // Main sequence: wrap corners, offset limits, returns back to back, then random traffic
  initial
  begin
    clk = 1'b0;
    ce  = 1'b1;
    void'($urandom(32'h1cf2_761f));
    do_reset();
    do_op(1, 0, 1, 0, 0, 0);
    do_op(1, 0, 0, 0, 0, 0);
    do_op(1, 0, 3, 0, 0, 0);
    do_op(1, 0, 2, 0, 0, 0);
    do_op(1, 1, 0, 1, -32, 0);
    do_op(1, 1, 0, 1, 31, 0);
    do_op(4, 0, 0, 0, 0, 0);
    do_op(5, 0, 0, 0, 0, 0);
    do_op(1, 1, 1, 0, 0, 0);
    do_op(1, 1, 3, 0, 0, 0);
    do_op(3, 0, 0, 0, 0, 1);
    do_op(0, 0, 0, 0, 0, 1);
    do_op(2, 0, 0, 0, 0, 0);
    // Clock enable low must freeze everything while a store is offered
    instr_op = OP_STORE;
    ce       = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check_all();
    ce = 1'b1;
    for (int i = 0; i < 300; i++)
    begin
      if (i == 200)
        do_reset();
      do_op($urandom_range(7), $urandom_range(1), $urandom_range(3), $urandom_range(1),
            int'($urandom_range(63)) - 32, $urandom_range(1));
    end
    close_out();
  end
endmodule : indirect_store_and_return_ops_bench
